// File: core/sasc_pkg.sv
package sasc_pkg;

  // Converter geometry
  localparam int          RES_W          = 12;
  localparam int          MAX_CH         = 16;
  localparam int          BASE_CH        = 8;
  localparam int          NCH            = MAX_CH + 1;
  localparam logic [4:0]  TEMP_CH        = 5'h10;
  localparam int          SAMP_W         = 8;

  // Timing at a 100 MHz clock
  localparam int          CLK_KHZ        = 100000;
  localparam int          MAX_RATE_KSPS  = 806;
  localparam int          AGG_RATE_KSPS  = 1000;
  localparam int          AGG_PERIOD_CYC = CLK_KHZ / AGG_RATE_KSPS;
  localparam int          MIN_PERIOD_CYC = (CLK_KHZ + MAX_RATE_KSPS - 1) / MAX_RATE_KSPS;
  localparam int          BIT_CYC        = 4;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFS       = 12'h000;
  localparam logic [11:0] FW_CONV_OFS    = 12'h004;
  localparam logic [11:0] CH_EN_OFS      = 12'h008;
  localparam logic [11:0] LIM_LO_OFS     = 12'h00c;
  localparam logic [11:0] LIM_HI_OFS     = 12'h010;
  localparam logic [11:0] INT_STAT_OFS   = 12'h014;
  localparam logic [11:0] INT_CLR_OFS    = 12'h018;
  localparam logic [11:0] INT_EN_OFS     = 12'h01c;
  localparam logic [11:0] STATE_OFS      = 12'h020;
  localparam logic [11:0] OOR_CH_OFS     = 12'h024;
  localparam logic [11:0] SAMP_BASE      = 12'h080;
  localparam logic [11:0] RES_BASE       = 12'h100;

  // Control field positions
  localparam int          CTRL_EN        = 0;
  localparam int          CTRL_AUTO      = 1;
  localparam int          CTRL_START     = 2;
  localparam int          CTRL_CONT      = 3;
  localparam int          CTRL_WIDE      = 4;
  localparam int          CTRL_REF_LSB   = 5;

  // Reference selections
  localparam logic [1:0]  REF_SUPPLY     = 2'h0;
  localparam logic [1:0]  REF_HALF       = 2'h1;
  localparam logic [1:0]  REF_BANDGAP    = 2'h2;
  localparam logic [1:0]  REF_EXT        = 2'h3;

  // Interrupt bits
  localparam int          INT_W          = 3;
  localparam int          INT_CONV       = 0;
  localparam int          INT_SCAN       = 1;
  localparam int          INT_OOR        = 2;

  // Reset values
  localparam logic [NCH-1:0]    CH_EN_RST  = 17'h000ff;
  localparam logic [RES_W-1:0]  LIM_LO_RST = 12'h000;
  localparam logic [RES_W-1:0]  LIM_HI_RST = 12'hfff;
  localparam logic [SAMP_W-1:0] SAMP_RST   = 8'h04;

  typedef struct packed {
    logic              last;
    logic [4:0]        ch;
    logic [SAMP_W-1:0] samp;
  } sasc_req_t;

  typedef struct packed {
    logic             last;
    logic [4:0]       ch;
    logic [RES_W-1:0] code;
  } sasc_res_t;

endpackage

// File: core/sasc_conv.sv
`timescale 1ns/100ps
module sasc_conv #(
  parameter int BIT_CYC    = sasc_pkg::BIT_CYC,
  parameter int PERIOD_CYC = sasc_pkg::AGG_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Request side
  input  wire logic                 run,
  input  wire logic                 start,
  input  wire sasc_pkg::sasc_req_t  req,
  output logic                      ready,
  // Result side
  output logic                      res_valid,
  output sasc_pkg::sasc_res_t       res,
  // Converter side
  output logic [4:0]                mux_sel,
  output logic                      track,
  output logic [11:0]               dac_code,
  input  wire logic                 cmp_pin
);

  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_SAMP = 4'b0010,
    CV_BITS = 4'b0100,
    CV_PAD  = 4'b1000
  } sasc_cv_t;

  localparam logic [7:0] BIT_N   = 8'(BIT_CYC);
  localparam logic [7:0] PER_END = 8'(PERIOD_CYC - 1);

  sasc_cv_t            state;
  sasc_cv_t            next_state;
  logic [7:0]          cnt;
  logic [7:0]          next_cnt;
  logic [7:0]          per;
  logic [7:0]          next_per;
  logic [3:0]          bitp;
  logic [3:0]          next_bitp;
  logic [11:0]         next_dac;
  logic [11:0]         trial;
  logic [4:0]          next_mux;
  logic                next_track;
  logic                next_valid;
  logic                tag_last;
  logic                next_last;
  logic [4:0]          tag_ch;
  logic [4:0]          next_ch;
  sasc_pkg::sasc_res_t next_res;
  logic                cmp_s1;
  logic                cmp_s2;
  logic                fin;

  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_per   = (per == 8'hff) ? per : per + 8'h01;
    next_bitp  = bitp;
    next_dac   = dac_code;
    next_mux   = mux_sel;
    next_track = track;
    next_valid = 1'b0;
    next_res   = res;
    next_last  = tag_last;
    next_ch    = tag_ch;
    fin        = 1'b0;
    // Keep the trial bit only when the comparator says input is above it
    trial      = cmp_s2 ? dac_code : (dac_code & ~(12'h001 << bitp));
    case (state)
      CV_IDLE:
      begin
        next_per = 8'h00;
      end
      CV_SAMP:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_track = 1'b0;
          next_state = CV_BITS;
          next_bitp  = 4'hb;
          next_dac   = 12'h800;
          next_cnt   = BIT_N;
        end
      end
      CV_BITS:
      begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01)
        begin
          next_cnt  = BIT_N;
          next_bitp = bitp - 4'h1;
          if (bitp == 4'h0)
          begin
            next_dac   = trial;
            next_res   = '{last: tag_last, ch: tag_ch, code: trial};
            next_valid = 1'b1;
            fin        = (per >= PER_END);
            next_state = fin ? CV_IDLE : CV_PAD;
          end
          else
          begin
            next_dac = trial | (12'h001 << (bitp - 4'h1));
          end
        end
      end
      CV_PAD:
      begin
        if (per >= PER_END)
        begin
          fin        = 1'b1;
          next_state = CV_IDLE;
        end
      end
      default:
      begin
        next_state = CV_IDLE;
      end
    endcase
    ready = run && ((state == CV_IDLE) || fin);
    // Back-to-back launch: the next channel enters sampling on the finishing edge
    if (start && ready)
    begin
      next_state = CV_SAMP;
      next_cnt   = (req.samp == 8'h00) ? 8'h01 : req.samp;
      next_per   = 8'h00;
      next_mux   = req.ch;
      next_track = 1'b1;
      next_last  = req.last;
      next_ch    = req.ch;
    end
    if (!run)
    begin
      next_state = CV_IDLE;
      next_track = 1'b0;
      next_valid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state     <= CV_IDLE;
      cnt       <= 8'h00;
      per       <= 8'h00;
      bitp      <= 4'h0;
      dac_code  <= 12'h000;
      mux_sel   <= 5'h00;
      track     <= 1'b0;
      res_valid <= 1'b0;
      res       <= '0;
      tag_last  <= 1'b0;
      tag_ch    <= 5'h00;
      cmp_s1    <= 1'b0;
      cmp_s2    <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      cnt       <= next_cnt;
      per       <= next_per;
      bitp      <= next_bitp;
      dac_code  <= next_dac;
      mux_sel   <= next_mux;
      track     <= next_track;
      res_valid <= next_valid;
      res       <= next_res;
      tag_last  <= next_last;
      tag_ch    <= next_ch;
      cmp_s1    <= cmp_pin;
      cmp_s2    <= cmp_s1;
    end
  end

endmodule

// File: core/sasc_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: Results are 12 bits; conversion rate reaches 806 ksps and beyond.
// R2: Sequencer routes 8 pin channels, extendable to 16.
// R3: Scan steps through software-selected channels with no processor help.
// R4: No idle cycles between channels; aggregate rate is 1 Msps.
// R5: Channel switching by hardware scan or by firmware writes, per configuration.
// R6: Each channel keeps its own result buffer.
// R7: Each channel has its own programmable sample time.
// R8: Low and high limits sit in two writable range registers.
// R9: Out-of-range result raises its interrupt at once, not at scan end.
// R10: Temperature sensor is a selectable conversion input.
// R11: Reference select picks supply, half supply, bandgap or external pin.
// R12: Sample-and-hold acquisition window length is programmable.
// R13: Converter stops in deep-sleep or hibernate modes.
// R14: Scan-complete event once every selected channel is converted and buffered.
// R15: Every new result of an enabled channel is checked against both limits.
module sasc_top #(
  parameter int BIT_CYC    = sasc_pkg::BIT_CYC,
  parameter int PERIOD_CYC = sasc_pkg::AGG_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Converter side
  output logic      [4:0]  mux_sel,
  output logic             track,
  output logic      [11:0] dac_code,
  output logic      [1:0]  ref_sel,
  input  wire logic        cmp_pin,
  // Power mode
  input  wire logic        sleep_pin
);

  localparam int         NCH  = sasc_pkg::NCH;
  localparam logic [4:0] NCH5 = 5'(sasc_pkg::NCH);

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_RUN  = 2'b10
  } sasc_seq_t;

  // Configuration
  logic                         en;
  logic                         auto_mode;
  logic                         cont;
  logic                         wide;
  logic [NCH-1:0]               ch_en;
  logic [11:0]                  lim_lo;
  logic [11:0]                  lim_hi;
  logic [2:0]                   int_en;
  logic [7:0]                   samp      [NCH];
  logic                         next_en;
  logic                         next_auto;
  logic                         next_cont;
  logic                         next_wide;
  logic [1:0]                   next_ref;
  logic [NCH-1:0]               next_ch_en;
  logic [11:0]                  next_lim_lo;
  logic [11:0]                  next_lim_hi;
  logic [2:0]                   next_int_en;
  logic [7:0]                   next_samp [NCH];
  // Bus
  logic [4:0]                   idx;
  logic                         in_samp;
  logic                         in_res;
  logic                         rd_hit;
  logic [31:0]                  rd_val;
  logic                         wr;
  logic                         rd;
  logic                         setup;
  // Sequencer
  sasc_seq_t                    sq;
  sasc_seq_t                    next_sq;
  logic [4:0]                   ptr;
  logic [4:0]                   next_ptr;
  logic                         start_pend;
  logic                         next_start_pend;
  logic                         fw_pend;
  logic                         next_fw_pend;
  logic [4:0]                   fw_ch;
  logic [4:0]                   next_fw_ch;
  logic [4:0]                   cur_ch;
  logic [4:0]                   next_cur_ch;
  logic [NCH-1:0]               act_mask;
  logic [5:0]                   hit_nxt;
  logic [5:0]                   hit_first;
  logic [5:0]                   hit_after;
  logic                         launch;
  sasc_pkg::sasc_req_t          req;
  logic                         cv_ready;
  logic                         cv_valid;
  sasc_pkg::sasc_res_t          cv_res;
  logic                         run;
  logic                         slp_s1;
  logic                         asleep;
  // Results and events
  logic [11:0]                  res_mem      [NCH];
  logic [11:0]                  next_res_mem [NCH];
  logic [NCH-1:0]               res_vld;
  logic [NCH-1:0]               next_res_vld;
  logic [NCH-1:0]               oor_ch;
  logic [NCH-1:0]               next_oor_ch;
  logic [2:0]                   int_stat;
  logic [2:0]                   next_int_stat;
  logic [2:0]                   ev;
  logic                         oor;

  // Lowest enabled channel at or above a start point, with a found flag on top
  function automatic logic [5:0] find_ch(input logic [NCH-1:0] mask, input logic [4:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (mask[i] && (5'(i) >= from))
      begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pready && pwrite;
  assign rd      = psel && penable && pready && !pwrite;
  assign idx     = paddr[6:2];
  assign in_samp = (paddr[11:7] == sasc_pkg::SAMP_BASE[11:7]) && (idx < NCH5);
  assign in_res  = (paddr[11:7] == sasc_pkg::RES_BASE[11:7]) && (idx < NCH5);

  // Register read mux
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (in_samp)
      rd_val = {24'h000000, samp[idx]};
    else if (in_res)
      rd_val = {res_vld[idx], 19'h00000, res_mem[idx]};
    else
    begin
      case (paddr)
        sasc_pkg::CTRL_OFS:     rd_val = {25'h0, ref_sel, wide, cont, 1'b0, auto_mode, en};
        sasc_pkg::FW_CONV_OFS:  rd_val = {27'h0, fw_ch};
        sasc_pkg::CH_EN_OFS:    rd_val = {15'h0, ch_en};
        sasc_pkg::LIM_LO_OFS:   rd_val = {20'h0, lim_lo};
        sasc_pkg::LIM_HI_OFS:   rd_val = {20'h0, lim_hi};
        sasc_pkg::INT_STAT_OFS: rd_val = {29'h0, int_stat};
        sasc_pkg::INT_CLR_OFS:  rd_val = 32'h0000_0000;
        sasc_pkg::INT_EN_OFS:   rd_val = {29'h0, int_en};
        sasc_pkg::STATE_OFS:    rd_val = {25'h0, cur_ch, asleep, (sq == SQ_RUN) || !cv_ready};
        sasc_pkg::OOR_CH_OFS:   rd_val = {15'h0, oor_ch};
        default:                rd_hit = 1'b0;
      endcase
    end
  end

  // Configuration writes
  always_comb
  begin
    next_en     = en;
    next_auto   = auto_mode;
    next_cont   = cont;
    next_wide   = wide;
    next_ref    = ref_sel;
    next_ch_en  = ch_en;
    next_lim_lo = lim_lo;
    next_lim_hi = lim_hi;
    next_int_en = int_en;
    next_samp   = samp;
    if (wr)
    begin
      if (in_samp)
        next_samp[idx] = pwdata[7:0];                                 // R7 R12
      case (paddr)
        sasc_pkg::CTRL_OFS:
        begin
          next_en   = pwdata[sasc_pkg::CTRL_EN];
          next_auto = pwdata[sasc_pkg::CTRL_AUTO];                    // R5
          next_cont = pwdata[sasc_pkg::CTRL_CONT];
          next_wide = pwdata[sasc_pkg::CTRL_WIDE];                    // R2
          next_ref  = pwdata[sasc_pkg::CTRL_REF_LSB +: 2];            // R11
        end
        sasc_pkg::CH_EN_OFS:  next_ch_en  = pwdata[NCH-1:0];          // R3
        sasc_pkg::LIM_LO_OFS: next_lim_lo = pwdata[11:0];             // R8
        sasc_pkg::LIM_HI_OFS: next_lim_hi = pwdata[11:0];             // R8
        sasc_pkg::INT_EN_OFS: next_int_en = pwdata[2:0];
        default:              next_int_en = next_int_en;
      endcase
    end
  end

  // Channels 8 to 15 join the scan only in the wide setting; the sensor is channel 16
  assign act_mask  = ch_en & {1'b1, {8{wide}}, 8'hff};                // R2 R10
  assign hit_nxt   = find_ch(act_mask, ptr);                          // R3
  assign hit_first = find_ch(act_mask, 5'h00);
  assign hit_after = find_ch(act_mask, hit_nxt[4:0] + 5'h01);
  assign run       = en && !asleep;                                   // R13

  // Sequencer
  always_comb
  begin
    next_sq         = sq;
    next_ptr        = ptr;
    next_cur_ch     = cur_ch;
    next_fw_ch      = fw_ch;
    next_start_pend = start_pend && auto_mode;
    next_fw_pend    = fw_pend && !auto_mode;
    launch          = 1'b0;
    req             = '{last: 1'b0, ch: fw_ch, samp: samp[fw_ch]};
    case (sq)
      SQ_IDLE:
      begin
        if (start_pend && auto_mode && run && hit_first[5])
        begin
          next_sq         = SQ_RUN;
          next_ptr        = hit_first[4:0];
          next_start_pend = 1'b0;
        end
        else if (fw_pend && !auto_mode && cv_ready)
        begin
          launch       = 1'b1;                                        // R5
          next_fw_pend = 1'b0;
          next_cur_ch  = fw_ch;
        end
      end
      SQ_RUN:
      begin
        if (!run || !auto_mode)
          next_sq = SQ_IDLE;
        else if (!hit_nxt[5])
        begin
          next_ptr = 5'h00;
          next_sq  = cont ? SQ_RUN : SQ_IDLE;
        end
        else if (cv_ready)
        begin
          launch      = 1'b1;                                         // R3 R4
          req         = '{last: !hit_after[5], ch: hit_nxt[4:0], samp: samp[hit_nxt[4:0]]}; // R7
          next_cur_ch = hit_nxt[4:0];
          next_ptr    = hit_nxt[4:0] + 5'h01;
          if (!hit_after[5])
          begin
            next_ptr = 5'h00;
            next_sq  = cont ? SQ_RUN : SQ_IDLE;
          end
        end
      end
      default:
      begin
        next_sq = SQ_IDLE;
      end
    endcase
    if (wr && paddr == sasc_pkg::CTRL_OFS && pwdata[sasc_pkg::CTRL_START])
      next_start_pend = pwdata[sasc_pkg::CTRL_AUTO];
    if (wr && paddr == sasc_pkg::FW_CONV_OFS && pwdata[4:0] < NCH5)
    begin
      next_fw_ch   = pwdata[4:0];                                     // R5 R10
      next_fw_pend = !auto_mode;
    end
  end

  // Results, range check and interrupt status
  always_comb
  begin
    next_res_mem = res_mem;
    next_res_vld = res_vld;
    next_oor_ch  = oor_ch;
    oor          = (cv_res.code < lim_lo) || (cv_res.code > lim_hi); // R15
    ev           = 3'h0;
    if (rd && in_res)
      next_res_vld[idx] = 1'b0;
    if (wr && paddr == sasc_pkg::OOR_CH_OFS)
      next_oor_ch = oor_ch & ~pwdata[NCH-1:0];
    if (cv_valid)
    begin
      next_res_mem[cv_res.ch] = cv_res.code;                          // R6 R1
      next_res_vld[cv_res.ch] = 1'b1;
      ev[sasc_pkg::INT_CONV]  = 1'b1;
      ev[sasc_pkg::INT_SCAN]  = cv_res.last;                          // R14
      ev[sasc_pkg::INT_OOR]   = oor;                                  // R9
      if (oor)
        next_oor_ch[cv_res.ch] = 1'b1;
    end
    next_int_stat = int_stat | ev;
    if (wr && paddr == sasc_pkg::INT_CLR_OFS)
      next_int_stat = (int_stat & ~pwdata[2:0]) | ev;
  end

  sasc_conv #(
    .BIT_CYC    (BIT_CYC),
    .PERIOD_CYC (PERIOD_CYC)
  ) u_conv (
    .clock     (clock),
    .rst_n     (rst_n),
    .run       (run),
    .start     (launch),
    .req       (req),
    .ready     (cv_ready),
    .res_valid (cv_valid),
    .res       (cv_res),
    .mux_sel   (mux_sel),
    .track     (track),
    .dac_code  (dac_code),
    .cmp_pin   (cmp_pin)
  );

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en         <= 1'b0;
      auto_mode  <= 1'b0;
      cont       <= 1'b0;
      wide       <= 1'b0;
      ref_sel    <= sasc_pkg::REF_SUPPLY;
      ch_en      <= sasc_pkg::CH_EN_RST;
      lim_lo     <= sasc_pkg::LIM_LO_RST;
      lim_hi     <= sasc_pkg::LIM_HI_RST;
      int_en     <= 3'h0;
      samp       <= '{default: sasc_pkg::SAMP_RST};
      sq         <= SQ_IDLE;
      ptr        <= 5'h00;
      start_pend <= 1'b0;
      fw_pend    <= 1'b0;
      fw_ch      <= 5'h00;
      cur_ch     <= 5'h00;
      res_mem    <= '{default: 12'h000};
      res_vld    <= '0;
      oor_ch     <= '0;
      int_stat   <= 3'h0;
      irq        <= 1'b0;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      slp_s1     <= 1'b0;
      asleep     <= 1'b0;
    end
    else
    begin
      en         <= next_en;
      auto_mode  <= next_auto;
      cont       <= next_cont;
      wide       <= next_wide;
      ref_sel    <= next_ref;
      ch_en      <= next_ch_en;
      lim_lo     <= next_lim_lo;
      lim_hi     <= next_lim_hi;
      int_en     <= next_int_en;
      samp       <= next_samp;
      sq         <= next_sq;
      ptr        <= next_ptr;
      start_pend <= next_start_pend;
      fw_pend    <= next_fw_pend;
      fw_ch      <= next_fw_ch;
      cur_ch     <= next_cur_ch;
      res_mem    <= next_res_mem;
      res_vld    <= next_res_vld;
      oor_ch     <= next_oor_ch;
      int_stat   <= next_int_stat;
      irq        <= |(int_stat & int_en);
      prdata     <= setup ? rd_val : prdata;
      pready     <= setup;
      pslverr    <= setup && !rd_hit;
      slp_s1     <= sleep_pin;
      asleep     <= slp_s1;                                           // R13
    end
  end

endmodule

// File: verification/sasc_top_properties.sv
`timescale 1ns/100ps
module sasc_top_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter side and power mode
  input wire logic [4:0]  mux_sel,
  input wire logic        track,
  input wire logic [11:0] dac_code,
  input wire logic [1:0]  ref_sel,
  input wire logic        sleep_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc_wr; psel && penable && pwrite && pready; endsequence
  sequence s_asleep; sleep_pin [*5]; endsequence
  property p_rdy; s_setup |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_ref; $changed(ref_sel) |-> $past(psel && penable && pwrite && pready); endproperty
  property p_mux; mux_sel <= 5'h10; endproperty
  property p_hold; track && $past(track) |-> $stable(mux_sel); endproperty
  property p_msb; $fell(track) && !sleep_pin |-> ##[0:1] dac_code == 12'h800; endproperty
  property p_sleep; s_asleep |-> !track; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  a_pulse: assert property (p_pulse) else $error("pready too long");
  a_err: assert property (p_err) else $error("pslverr without pready");
  a_ref: assert property (p_ref) else $error("ref_sel moved alone");
  a_mux: assert property (p_mux) else $error("bad channel");
  a_hold: assert property (p_hold) else $error("mux moved in track");
  a_msb: assert property (p_msb) else $error("first trial not msb");
  a_sleep: assert property (p_sleep) else $error("track in sleep");
  c_wr: cover property (s_acc_wr);
endmodule

bind sasc_top sasc_top_chk u_chk (.*);

// File: verification/sasc_ain.sv
`timescale 1ns/100ps
module sasc_ain (
  // Converter side
  input  wire logic [4:0]  mux_sel,
  input  wire logic [11:0] dac_code,
  output logic             cmp_pin
);
  // Input level per channel, 16 is the temperature sensor
  logic [11:0] level [0:16];
  assign cmp_pin = level[mux_sel] >= dac_code;
endmodule

// File: verification/sasc_top_tb.sv
`timescale 1ns/100ps
module sasc_top_tb;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic        sleep_pin = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, track, cmp_pin, e, tp;
  logic [4:0]  mux_sel;
  logic [11:0] dac_code;
  logic [1:0]  ref_sel;
  logic [31:0] v;
  int          err_count, check_count, tl, cyc;
  int          lt[$];
  logic [4:0]  lc[$];
  int          tlen [0:16];

  always #5 clock = ~clock;

  sasc_top #(.PERIOD_CYC(60)) dut (.*);
  sasc_ain ain (.mux_sel(mux_sel), .dac_code(dac_code), .cmp_pin(cmp_pin));

  // Launch times, channels and track lengths
  always @(posedge clock)
  begin
    cyc++;
    if (track && !tp)
    begin
      lt.push_back(cyc);
      lc.push_back(mux_sel);
    end
    if (track)
      tl++;
    else if (tp)
    begin
      tlen[lc[$]] = tl;
      tl = 0;
    end
    tp = track;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    v = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), x, v);
  endtask

  task automatic wirq;
    repeat (300) if (irq !== 1'h1) @(posedge clock);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100us;
    err_count++;
    give_verdict;
  end

  initial
  begin
    ain.level[0] = 12'h050;
    ain.level[2] = 12'h400;
    ain.level[5] = 12'h123;
    ain.level[16] = 12'h7ff;
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    rc(12'h008, 32'h000ff);
    rc(12'h010, 32'h00fff);
    rc(12'h080, 32'h4);
    rc(12'h030, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    for (int r = 0; r < 4; r++)
    begin
      xfer(1'h1, 12'h000, 32'(r) << 5);
      chk("ref_sel", r, ref_sel);
    end
    // Scan of ch0, ch2 and the sensor with distinct sample times
    xfer(1'h1, 12'h00c, 32'h100);
    xfer(1'h1, 12'h010, 32'h700);
    xfer(1'h1, 12'h080, 32'hc);
    xfer(1'h1, 12'h088, 32'h1);
    xfer(1'h1, 12'h0c0, 32'h3);
    // Channel 8 is enabled but must be skipped while the wide setting is off
    xfer(1'h1, 12'h008, 32'h10105);
    xfer(1'h1, 12'h01c, 32'h4);
    xfer(1'h1, 12'h000, 32'h47);
    chk("ref_sel", 32'h2, ref_sel);
    wirq;
    rc(12'h014, 32'h5);
    xfer(1'h1, 12'h01c, 32'h0);
    @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    repeat (100)
    begin
      xfer(1'h0, 12'h014, 32'h0);
      if (v[1])
        break;
    end
    chk("scan", 32'h7, v);
    chk("launches", 32'h3, lc.size());
    chk("order", 32'h0050, {lc[0], lc[1], lc[2]});
    chk("gap", 32'h003c003c, {16'(lt[1] - lt[0]), 16'(lt[2] - lt[1])});
    chk("track", 32'h0c0103, {8'(tlen[0]), 8'(tlen[2]), 8'(tlen[16])});
    rc(12'h100, 32'h80000050);
    rc(12'h108, 32'h80000400);
    rc(12'h140, 32'h800007ff);
    rc(12'h100, 32'h00000050);
    rc(12'h024, 32'h10001);
    xfer(1'h1, 12'h018, 32'h7);
    rc(12'h014, 32'h0);
    // Firmware driven conversion
    xfer(1'h1, 12'h01c, 32'h1);
    xfer(1'h1, 12'h000, 32'h1);
    xfer(1'h1, 12'h004, 32'h5);
    wirq;
    chk("irq", 32'h1, {31'h0, irq});
    rc(12'h014, 32'h1);
    rc(12'h114, 32'h80000123);
    chk("fw ch", 32'h5, lc[3]);
    // Channel with bit 1 set in its number
    xfer(1'h1, 12'h018, 32'h7);
    xfer(1'h1, 12'h004, 32'h2);
    wirq;
    rc(12'h108, 32'h80000400);
    chk("fw ch2", 32'h2, lc[4]);
    // No conversion while asleep
    xfer(1'h1, 12'h018, 32'h7);
    sleep_pin <= 1'h1;
    repeat (4) @(posedge clock);
    xfer(1'h1, 12'h004, 32'h5);
    repeat (100) @(posedge clock);
    rc(12'h014, 32'h0);
    chk("sleep", 32'h5, lc.size());
    give_verdict;
  end
endmodule
